// ---- bench/engine_port_sva.sv ----
// engine_port_sva: port checks for the engine host port
// assumes: bound to engine_host_port, one clock, async high reset
`timescale 1ns/100ps
module engine_port_sva #(
  parameter int INT_W = 9
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic ENGINE_SELECT_N_IN,
  input wire logic ENGINE_READ_STROBE_N_IN,
  input wire logic ENGINE_WRITE_STROBE_N_IN,
  input wire logic [INT_W-1:0] INT_EVENT_IN,
  input wire logic [INT_W-1:0] INT_STATUS_OUT,
  input wire logic INT_REQ_N_OUT,
  input wire logic DATA_OE_OUT
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  event_sets_a: assert property ((INT_EVENT_IN != 0) |=>
    ((INT_STATUS_OUT & $past(INT_EVENT_IN)) == $past(INT_EVENT_IN)))
    else $error("event bit not latched");
  only_event_a: assert property (
    (INT_STATUS_OUT & ~$past(INT_STATUS_OUT) & ~$past(INT_EVENT_IN)) == 0)
    else $error("status bit set without event");
  clear_by_ack_a: assert property (
    ((~INT_STATUS_OUT & $past(INT_STATUS_OUT)) != 0)
    |-> !$past(ENGINE_WRITE_STROBE_N_IN, 3))
    else $error("status cleared without write");
  req_idle_a: assert property ((INT_STATUS_OUT == 0) |-> INT_REQ_N_OUT)
    else $error("request with empty status");
  drive_read_a: assert property (
    DATA_OE_OUT |-> !$past(ENGINE_READ_STROBE_N_IN, 3))
    else $error("bus driven without read");
  read_drives_a: assert property (
    (!$past(ENGINE_READ_STROBE_N_IN, 3) && !$past(ENGINE_SELECT_N_IN, 3))
    |-> DATA_OE_OUT)
    else $error("selected read left bus undriven");
endmodule : engine_port_sva
bind engine_host_port engine_port_sva #(.INT_W(INT_W)) chk_i (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .ENGINE_SELECT_N_IN(ENGINE_SELECT_N_IN),
  .ENGINE_READ_STROBE_N_IN(ENGINE_READ_STROBE_N_IN),
  .ENGINE_WRITE_STROBE_N_IN(ENGINE_WRITE_STROBE_N_IN),
  .INT_EVENT_IN(INT_EVENT_IN), .INT_STATUS_OUT(INT_STATUS_OUT),
  .INT_REQ_N_OUT(INT_REQ_N_OUT), .DATA_OE_OUT(DATA_OE_OUT));

// ---- bench/host_model.sv ----
// host_model: host side that issues one access at a time to the engine
// assumes: strobes launched on rising edge, held five clocks each way
`timescale 1ns/100ps
module host_model (
  input wire logic clk_in,
  output logic sel_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [1:0] addr_out,
  output logic [15:0] data_out
);
  // ****
  // access
  // ****
  initial begin
    {sel_n_out, rd_n_out, wr_n_out, addr_out, data_out} = '1;
  end
  // one access; only one strobe low, unique select per engine
  task automatic acc(input logic rd, input logic sel, input logic [1:0] a,
                     input logic [15:0] d);
    @(posedge clk_in);
    // select low only when sel is set, already synchronous here
    sel_n_out <= !sel;
    rd_n_out <= !rd;
    wr_n_out <= rd;
    addr_out <= a;
    data_out <= d;
    // fixed five-clock strobe stands in for the acknowledge sequencer
    repeat (5) @(posedge clk_in);
    // strobes and select rise together once the cycle is acknowledged
    {sel_n_out, rd_n_out, wr_n_out} <= 3'h7;
    data_out <= ~d; // released bus does not keep its value
    repeat (5) @(posedge clk_in);
  endtask : acc
endmodule : host_model

// ---- bench/testbench.sv ----
// testbench: drives the engine host port through the host model
// assumes: 250 MHz clock, reset held twelve cycles
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] ev = 9'h000;
  logic sel_n, rd_n, wr_n, oe, req_n;
  logic [1:0] addr;
  logic [15:0] wdat, rdat;
  logic [8:0] stat;
  int n_errors = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  host_model host (.clk_in(clk), .sel_n_out(sel_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .data_out(wdat));
  engine_host_port dut (.CLK_IN(clk), .RST_IN(rst),
    .ENGINE_SELECT_N_IN(sel_n), .ENGINE_READ_STROBE_N_IN(rd_n),
    .ENGINE_WRITE_STROBE_N_IN(wr_n), .REG_ADDR_IN(addr),
    .DATA_IN(wdat), .INT_EVENT_IN(ev), .DATA_OUT(rdat),
    .DATA_OE_OUT(oe), .INT_STATUS_OUT(stat), .INT_REQ_N_OUT(req_n));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [8:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 9'h000;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ****
  // scenarios
  // ****
  task automatic t_raise_read;
    host.acc(1'b0, 1'b1, 2'h2, 16'h01ff);
    pulse(9'h105);
    chk({7'h00, stat}, 16'h0105);
    chk({15'h0000, req_n}, 16'h0000);
    fork
      host.acc(1'b1, 1'b1, 2'h0, 16'h0000);
      begin
        repeat (5) @(posedge clk);
        chk({15'h0000, oe}, 16'h0001);
        chk(rdat, 16'h0105);
      end
    join
    chk(rdat, 16'h0105);
    chk({15'h0000, oe}, 16'h0000);
    host.acc(1'b1, 1'b1, 2'h2, 16'h0000);
    chk(rdat, 16'h01ff);
    host.acc(1'b1, 1'b1, 2'h1, 16'h0000);
    chk(rdat, 16'h0000);
  endtask : t_raise_read
  task automatic t_ack;
    host.acc(1'b0, 1'b0, 2'h1, 16'h0105); // no select: ignored
    chk({7'h00, stat}, 16'h0105);
    host.acc(1'b0, 1'b1, 2'h1, 16'h0004);
    chk({7'h00, stat}, 16'h0101);
    chk({15'h0000, req_n}, 16'h0000);
    host.acc(1'b0, 1'b1, 2'h1, 16'h0101);
    chk({7'h00, stat}, 16'h0000);
    chk({15'h0000, req_n}, 16'h0001);
  endtask : t_ack
  task automatic t_masked;
    host.acc(1'b0, 1'b1, 2'h2, 16'h0000);
    pulse(9'h080);
    chk({7'h00, stat}, 16'h0080);
    chk({15'h0000, req_n}, 16'h0001);
    host.acc(1'b1, 1'b1, 2'h3, 16'h0000);
    chk(rdat, 16'h0000);
  endtask : t_masked
  // ****
  // main sequence and watchdog
  // ****
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({6'h00, stat, req_n}, 16'h0001);
    t_raise_read();
    t_ack();
    t_masked();
    tally_and_finish();
  end
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end
endmodule : testbench

// ---- logic/engine_bus_pkg.sv ----
// engine_bus_pkg: constants shared by the engine host port logic
// assumes: plain SystemVerilog package, referenced as engine_bus_pkg::name
package engine_bus_pkg;

  // ****************************************************
  // port layout
  // ****************************************************
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam int INT_W = 9;

  // ****************************************************
  // register indexes on the host port
  // ****************************************************
  localparam logic [1:0] IDX_STATUS = 2'h0;
  localparam logic [1:0] IDX_INT_ACK = 2'h1;
  localparam logic [1:0] IDX_INT_MASK = 2'h2;

  // ****************************************************
  // values after reset
  // ****************************************************
  localparam logic [8:0] RST_INT_STATUS = 9'h000;
  localparam logic [8:0] RST_INT_MASK = 9'h000;
  localparam logic [15:0] RST_READ_DATA = 16'h0000;

  // ****************************************************
  // strobe synchroniser depth (two flops, one edge stage)
  // ****************************************************
  localparam int SYNC_STAGES = 2;

endpackage : engine_bus_pkg

// ---- logic/engine_host_port.sv ----
// engine_host_port: host-side status, interrupt mask and acknowledge logic
// assumes: host strobes may be asynchronous to CLK_IN; core events are
// one-cycle pulses that every engine in the system sees in the same cycle
`timescale 1ns/100ps
module engine_host_port #(
  parameter int DATA_W = engine_bus_pkg::DATA_W,
  parameter int INT_W = engine_bus_pkg::INT_W
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic ENGINE_SELECT_N_IN,
  input wire logic ENGINE_READ_STROBE_N_IN,
  input wire logic ENGINE_WRITE_STROBE_N_IN,
  input wire logic [engine_bus_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic [INT_W-1:0] INT_EVENT_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_OUT,
  output logic [INT_W-1:0] INT_STATUS_OUT,
  output logic INT_REQ_N_OUT
);

  // ****************************************************
  // strobe synchronisation
  // ****************************************************

  strobe_sync_if sync_bus ();

  // raw strobes enter the synchroniser, never the logic below
  assign sync_bus.select_raw_n = ENGINE_SELECT_N_IN;
  assign sync_bus.read_raw_n = ENGINE_READ_STROBE_N_IN;
  assign sync_bus.write_raw_n = ENGINE_WRITE_STROBE_N_IN;

  strobe_sync u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .bus(sync_bus.sync)
  );

  // ****************************************************
  // state
  // ****************************************************

  typedef struct packed {
    logic [INT_W-1:0] status;  // sticky interrupt conditions
    logic [INT_W-1:0] mask;    // one enables a condition onto the request
    logic [DATA_W-1:0] rdata;  // read data, held while the read lasts
    logic oe;                  // data bus driven
    logic req_n;               // interrupt request, active low
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [INT_W-1:0] ack_clear;
  logic wr_take;
  logic rd_take;

  // ****************************************************
  // access decode
  // ****************************************************

  // a write is taken once its synchronised strobe asserts with select, so
  // data had two clocks to settle; the host holds the cycle meanwhile
  assign wr_take = sync_bus.write_rise & sync_bus.select_act;
  assign rd_take = sync_bus.read_rise & sync_bus.select_act;

  // ones written to the acknowledge index clear those status bits; the
  // same write broadcast to all engines clears all of them alike
  always_comb begin
    ack_clear = '0;
    if (wr_take && REG_ADDR_IN == engine_bus_pkg::IDX_INT_ACK) begin
      ack_clear = DATA_IN[INT_W-1:0];
    end
  end

  // ****************************************************
  // next state
  // ****************************************************

  always_comb begin
    s_d = s_q;
    // lockstep events set the same bits in every engine; a new event wins
    // over a clear in the same cycle so no condition is lost
    s_d.status = (s_q.status & ~ack_clear) | INT_EVENT_IN;
    if (wr_take && REG_ADDR_IN == engine_bus_pkg::IDX_INT_MASK) begin
      s_d.mask = DATA_IN[INT_W-1:0];
    end
    // request stays low until every unmasked condition is acknowledged
    s_d.req_n = ~|(s_d.status & s_d.mask);
    // read data captured at the start of the read and held until the next read is taken
    if (rd_take) begin
      s_d.rdata = '0;
      unique case (REG_ADDR_IN)
        engine_bus_pkg::IDX_STATUS: begin
          s_d.rdata[INT_W-1:0] = s_q.status;
        end
        engine_bus_pkg::IDX_INT_MASK: begin
          s_d.rdata[INT_W-1:0] = s_q.mask;
        end
        default: begin
          s_d.rdata = '0; // acknowledge and spare indexes read zero
        end
      endcase
    end
    s_d.oe = sync_bus.read_act;
  end

  // ****************************************************
  // registers
  // ****************************************************

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s_q.status <= engine_bus_pkg::RST_INT_STATUS;
      s_q.mask <= engine_bus_pkg::RST_INT_MASK;
      s_q.rdata <= engine_bus_pkg::RST_READ_DATA;
      s_q.oe <= 1'b0;
      s_q.req_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign DATA_OUT = s_q.rdata;
  assign DATA_OE_OUT = s_q.oe;
  assign INT_STATUS_OUT = s_q.status;
  assign INT_REQ_N_OUT = s_q.req_n;

endmodule : engine_host_port

// ---- logic/strobe_sync.sv ----
// strobe_sync: two-flop synchroniser for the select and strobes, with edges
// assumes: one clock, async active-high reset, inputs active low
`timescale 1ns/100ps
module strobe_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  strobe_sync_if.sync bus
);

  typedef struct packed {
    logic [2:0] meta;   // first stage, read only by the second
    logic [2:0] stable; // second stage, active high
    logic [2:0] last;   // previous stable value for edge detection
  } state_t;

  state_t s_q;
  state_t s_d;

  // shift active-high copies of select, read, write through the stages
  always_comb begin
    s_d = s_q;
    s_d.meta = {~bus.write_raw_n, ~bus.read_raw_n, ~bus.select_raw_n};
    s_d.stable = s_q.meta;
    s_d.last = s_q.stable;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // levels and pulses taken from the stable and last stages only
  assign bus.select_act = s_q.stable[0];
  assign bus.read_act = s_q.stable[1] & s_q.stable[0];
  assign bus.read_rise = s_q.stable[1] & ~s_q.last[1];
  assign bus.write_rise = s_q.stable[2] & ~s_q.last[2];

endmodule : strobe_sync

// ---- logic/strobe_sync_if.sv ----
// strobe_sync_if: carries the host strobes into and out of the synchroniser
// assumes: raw side is asynchronous, synced side is on the engine clock
`timescale 1ns/100ps
interface strobe_sync_if;
  logic select_raw_n;
  logic read_raw_n;
  logic write_raw_n;
  logic select_act;
  logic read_act;
  logic write_rise;
  logic read_rise;

  modport sync (
    input select_raw_n, read_raw_n, write_raw_n,
    output select_act, read_act, write_rise, read_rise
  );
  modport user (
    output select_raw_n, read_raw_n, write_raw_n,
    input select_act, read_act, write_rise, read_rise
  );
endinterface : strobe_sync_if
